// *** rtl/dtp_timers.sv ***
// file: dual 8-bit timer with pwm and tone output, axi4-lite registers
`timescale 1ns/100ps
module dtp_timers #(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write address and data
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    // axi4-lite write response
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // count sources and configuration straps
    input wire logic ext_count_clock_pin,
    input wire logic slow_internal_osc,
    input wire logic cfg_async_count,
    input wire logic cfg_pin2_tone,
    // shared output pin and interrupt request
    output logic shared_port_pin_2_out,
    output logic shared_port_pin_2_oe,
    output logic irq_req
);
    if (ADDR_W < 8)
    begin : g_check
        $error("dtp_timers: address bus narrower than register map");
    end

    function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
        is_mapped = (a[ADDR_W-1:6] == '0) && (a[1:0] == 2'b00) && (a[7:0] <= dtp_pkg::ADDR_IRQ_ENABLE);
    endfunction : is_mapped

    function automatic logic edge_hit(input logic prev, input logic cur, input logic fall);
        edge_hit = fall ? (prev && !cur) : (!prev && cur);
    endfunction : edge_hit

    // registers
    logic [7:0] up_count;
    dtp_pkg::dtp_up_mode_type up_mode;
    logic count_up_run;
    logic global_irq_en;
    logic [7:0] down_count;
    logic [7:0] down_reload_value;
    logic down_done;
    dtp_pkg::dtp_ctrl_a_type ctrl_a;
    dtp_pkg::dtp_ctrl_b_type ctrl_b;
    logic [7:0] pulse_duty_value;
    dtp_pkg::dtp_tone_type tone_ctrl;
    logic up_overflow_flag;
    logic down_underflow_flag;
    logic up_overflow_irq_en;
    logic down_underflow_irq_en;
    logic tone_level;

    // write channel holding state
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane0;
    logic wr_fire;

    // address and data are taken independently, the response waits for both
    assign awready = !aw_held;
    assign wready = !w_held;
    assign wr_fire = aw_held && w_held && !bvalid;
    assign arready = !rvalid;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            w_byte <= dtp_pkg::RST_BYTE;
            w_lane0 <= 1'b0;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= awaddr;
            end
            else if (wr_fire)
                aw_held <= 1'b0;
            if (wvalid && wready)
            begin
                w_held <= 1'b1;
                w_byte <= wdata[7:0];
                w_lane0 <= wstrb[0];
            end
            else if (wr_fire)
                w_held <= 1'b0;
        end
    end

    // write response, error for holes in the map
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            bvalid <= 1'b0;
            bresp <= dtp_pkg::RESP_OKAY;
        end
        else if (wr_fire)
        begin
            bvalid <= 1'b1;
            bresp <= is_mapped(aw_addr) ? dtp_pkg::RESP_OKAY : dtp_pkg::RESP_SLVERR;
        end
        else if (bready)
            bvalid <= 1'b0;
    end

    // byte 0 strobe gates every write, upper lanes are ignored
    logic wr_any;
    logic wr_up_count, wr_up_mode, wr_power, wr_down_count, wr_ctrl_a, wr_ctrl_b;
    logic wr_duty, wr_tone, wr_flag, wr_enable;
    assign wr_any = wr_fire && w_lane0 && is_mapped(aw_addr);
    assign wr_up_count = wr_any && (aw_addr[7:0] == dtp_pkg::ADDR_UP_COUNT);
    assign wr_up_mode = wr_any && (aw_addr[7:0] == dtp_pkg::ADDR_UP_MODE);
    assign wr_power = wr_any && (aw_addr[7:0] == dtp_pkg::ADDR_POWER_CTRL_1);
    assign wr_down_count = wr_any && (aw_addr[7:0] == dtp_pkg::ADDR_DOWN_COUNT);
    assign wr_ctrl_a = wr_any && (aw_addr[7:0] == dtp_pkg::ADDR_DOWN_CTRL_A);
    assign wr_ctrl_b = wr_any && (aw_addr[7:0] == dtp_pkg::ADDR_DOWN_CTRL_B);
    assign wr_duty = wr_any && (aw_addr[7:0] == dtp_pkg::ADDR_PULSE_DUTY);
    assign wr_tone = wr_any && (aw_addr[7:0] == dtp_pkg::ADDR_TONE_CTRL);
    assign wr_flag = wr_any && (aw_addr[7:0] == dtp_pkg::ADDR_IRQ_FLAG);
    assign wr_enable = wr_any && (aw_addr[7:0] == dtp_pkg::ADDR_IRQ_ENABLE);

    // plain control registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            up_mode <= dtp_pkg::RST_BYTE;
            count_up_run <= 1'b0;
            global_irq_en <= 1'b0;
            ctrl_a <= dtp_pkg::RST_BYTE;
            ctrl_b <= dtp_pkg::RST_BYTE;
            pulse_duty_value <= dtp_pkg::RST_BYTE;
            tone_ctrl <= dtp_pkg::RST_BYTE;
            up_overflow_irq_en <= 1'b0;
            down_underflow_irq_en <= 1'b0;
        end
        else
        begin
            if (wr_up_mode)
                up_mode <= w_byte;
            if (wr_power)
            begin
                count_up_run <= w_byte[dtp_pkg::BIT_RUN];
                global_irq_en <= w_byte[dtp_pkg::BIT_GIE];
            end
            if (wr_ctrl_a)
                ctrl_a <= w_byte;
            if (wr_ctrl_b)
                ctrl_b <= w_byte;
            if (wr_duty)
                pulse_duty_value <= w_byte;
            if (wr_tone)
                tone_ctrl <= w_byte;
            if (wr_enable)
            begin
                up_overflow_irq_en <= w_byte[dtp_pkg::BIT_IRQ_UP];
                down_underflow_irq_en <= w_byte[dtp_pkg::BIT_IRQ_DOWN];
            end
        end
    end

    // source sampling: a two-stage synchroniser plus a history stage for edges,
    // and a single raw stage for the async option, which trades metastability margin for speed
    logic pin_s1, pin_s2, pin_s3, osc_s1, osc_s2, osc_s3;
    logic pin_raw, pin_raw_d, osc_raw, osc_raw_d;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            {pin_s1, pin_s2, pin_s3, osc_s1, osc_s2, osc_s3} <= 6'h00;
            {pin_raw, pin_raw_d, osc_raw, osc_raw_d} <= 4'h0;
        end
        else
        begin
            {pin_s1, pin_s2, pin_s3} <= {ext_count_clock_pin, pin_s1, pin_s2};
            {osc_s1, osc_s2, osc_s3} <= {slow_internal_osc, osc_s1, osc_s2};
            {pin_raw, pin_raw_d} <= {ext_count_clock_pin, pin_raw};
            {osc_raw, osc_raw_d} <= {slow_internal_osc, osc_raw};
        end
    end

    // up timer source selection and edge detection
    logic up_cur, up_prev, up_src_tick;
    always_comb
    begin
        if (cfg_async_count)
        begin
            up_cur = up_mode.low_clk_sel ? osc_raw : pin_raw;
            up_prev = up_mode.low_clk_sel ? osc_raw_d : pin_raw_d;
        end
        else
        begin
            up_cur = up_mode.low_clk_sel ? osc_s2 : pin_s2;
            up_prev = up_mode.low_clk_sel ? osc_s3 : pin_s3;
        end
        // clock select clear means one tick per instruction clock
        up_src_tick = !up_mode.clk_sel || edge_hit(up_prev, up_cur, up_mode.edge_fall);
    end

    // shared prescaler, cleared by the write that assigns it to this timer
    logic p0_tick, p0_clear;
    logic [7:0] p0_value;
    assign p0_clear = wr_up_mode && !w_byte[dtp_pkg::BIT_UP_ASSIGN];
    dtp_divider u_up_presc (
        .aclk(aclk),
        .aresetn(aresetn),
        .clear(p0_clear),
        .tick(up_src_tick && !up_mode.assign_other),
        .sel(up_mode.ratio),
        .out_tick(p0_tick),
        .value(p0_value)
    );

    logic up_tick, up_ovf;
    assign up_tick = count_up_run && (up_mode.assign_other ? up_src_tick : p0_tick);
    assign up_ovf = up_tick && !wr_up_count && (up_count == dtp_pkg::UP_LAST);

    // up counter, a firmware load beats a tick in the same cycle
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            up_count <= dtp_pkg::RST_BYTE;
        else if (wr_up_count)
            up_count <= w_byte;
        else if (up_tick)
            up_count <= up_count + 8'h01;
    end

    // down timer source, always synchronised
    logic dn_src_tick, p1_tick, dn_tick, dn_uflow;
    logic [7:0] p1_value;
    assign dn_src_tick = !ctrl_b.clk_sel || edge_hit(pin_s3, pin_s2, ctrl_b.edge_fall);
    dtp_divider u_down_presc (
        .aclk(aclk),
        .aresetn(aresetn),
        .clear(!ctrl_a.run),
        .tick(dn_src_tick),
        .sel(ctrl_b.ratio),
        .out_tick(p1_tick),
        .value(p1_value)
    );
    assign dn_tick = ctrl_a.run && !down_done && (ctrl_b.presc_en_n ? dn_src_tick : p1_tick);
    assign dn_uflow = dn_tick && !wr_down_count && (down_count == 8'h00);

    // down counter with reload and one-shot stop; disabling rearms a finished one-shot
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            down_count <= dtp_pkg::RST_BYTE;
            down_reload_value <= dtp_pkg::RST_BYTE;
            down_done <= 1'b0;
        end
        else if (wr_down_count)
        begin
            down_count <= w_byte;
            down_reload_value <= w_byte;
            down_done <= 1'b0;
        end
        else if (dn_uflow)
        begin
            if (ctrl_a.one_shot)
                down_done <= 1'b1;
            else
                down_count <= ctrl_a.reload_sel ? down_reload_value : dtp_pkg::DOWN_RESTART;
        end
        else
        begin
            if (dn_tick)
                down_count <= down_count - 8'h01;
            if (!ctrl_a.run)
                down_done <= 1'b0;
        end
    end

    // sticky flags: a set in the clearing cycle wins
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            up_overflow_flag <= 1'b0;
            down_underflow_flag <= 1'b0;
        end
        else
        begin
            up_overflow_flag <= up_ovf || (up_overflow_flag && !(wr_flag && !w_byte[dtp_pkg::BIT_IRQ_UP]));
            down_underflow_flag <= dn_uflow
                || (down_underflow_flag && !(wr_flag && !w_byte[dtp_pkg::BIT_IRQ_DOWN]));
        end
    end

    // interrupt request level
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            irq_req <= 1'b0;
        else
            irq_req <= global_irq_en && ((up_overflow_flag && up_overflow_irq_en)
                || (down_underflow_flag && down_underflow_irq_en));
    end

    // tone divider fed by prescaler output or timer underflow
    logic tone_src, tone_tick;
    assign tone_src = tone_ctrl.freq[3] ? dn_uflow : p1_tick;
    dtp_divider u_tone_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .clear(!tone_ctrl.en),
        .tick(tone_src),
        .sel(tone_ctrl.freq[2:0]),
        .out_tick(tone_tick),
        .value()
    );
    always_ff @(posedge aclk)
    begin
        if (!aresetn || !tone_ctrl.en)
            tone_level <= 1'b0;
        else if (tone_tick)
            tone_level <= !tone_level;
    end

    // pulse is active while the count sits below the duty value
    logic pulse_active;
    assign pulse_active = down_count < pulse_duty_value;

    // shared pin, pulse takes the pin when strapped for it
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            shared_port_pin_2_out <= 1'b0;
            shared_port_pin_2_oe <= 1'b0;
        end
        else if (ctrl_a.pulse_en && !cfg_pin2_tone)
        begin
            shared_port_pin_2_out <= pulse_active ^ ctrl_a.active_low;
            shared_port_pin_2_oe <= 1'b1;
        end
        else if (tone_ctrl.en && cfg_pin2_tone)
        begin
            shared_port_pin_2_out <= tone_level;
            shared_port_pin_2_oe <= 1'b1;
        end
        else
        begin
            shared_port_pin_2_out <= 1'b0;
            shared_port_pin_2_oe <= 1'b0;
        end
    end

    // read path, one cycle after the address is taken
    logic [7:0] rd_byte;
    always_comb
    begin
        case (araddr[7:0])
            dtp_pkg::ADDR_UP_COUNT: rd_byte = up_count;
            dtp_pkg::ADDR_UP_MODE: rd_byte = up_mode;
            dtp_pkg::ADDR_POWER_CTRL_1: rd_byte = {global_irq_en, 6'h00, count_up_run};
            dtp_pkg::ADDR_DOWN_COUNT: rd_byte = down_count;
            dtp_pkg::ADDR_DOWN_CTRL_A: rd_byte = ctrl_a;
            dtp_pkg::ADDR_DOWN_CTRL_B: rd_byte = ctrl_b;
            dtp_pkg::ADDR_DOWN_PRESC: rd_byte = p1_value;
            dtp_pkg::ADDR_PULSE_DUTY: rd_byte = pulse_duty_value;
            dtp_pkg::ADDR_TONE_CTRL: rd_byte = tone_ctrl;
            dtp_pkg::ADDR_IRQ_FLAG: rd_byte = {4'h0, down_underflow_flag, 2'b00, up_overflow_flag};
            dtp_pkg::ADDR_IRQ_ENABLE: rd_byte = {4'h0, down_underflow_irq_en, 2'b00, up_overflow_irq_en};
            default: rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= dtp_pkg::RESP_OKAY;
        end
        else if (arvalid && arready)
        begin
            rvalid <= 1'b1;
            rdata <= is_mapped(araddr) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            rresp <= is_mapped(araddr) ? dtp_pkg::RESP_OKAY : dtp_pkg::RESP_SLVERR;
        end
        else if (rready)
            rvalid <= 1'b0;
    end

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_UP_HOLD: assert property (!count_up_run && !wr_up_count |=> $stable(up_count))
        else $error("up timer moved while stopped");
    AST_UP_LOAD: assert property (wr_up_count |=> up_count == $past(w_byte))
        else $error("up timer load lost");
    AST_P0_CLEAR: assert property (p0_clear |=> p0_value == 8'h00)
        else $error("shared prescaler not cleared");
    AST_UP_OVF: assert property (up_ovf |=> up_overflow_flag && up_count == 8'h00)
        else $error("overflow did not set flag");
    AST_FLAG_STICKY: assert property (up_overflow_flag && !wr_flag |=> up_overflow_flag)
        else $error("flag dropped without a clear");
    AST_IRQ: assert property (global_irq_en && down_underflow_irq_en && down_underflow_flag
        && !wr_power && !wr_enable |=> irq_req)
        else $error("interrupt not requested");
    AST_DN_LOAD: assert property (wr_down_count |=> down_count == down_reload_value
        && down_count == $past(w_byte))
        else $error("down timer load lost");
    AST_DN_RELOAD: assert property (dn_uflow && !ctrl_a.one_shot && ctrl_a.reload_sel
        |=> down_count == down_reload_value && down_underflow_flag)
        else $error("reload restart wrong");
    AST_DN_RESTART: assert property (dn_uflow && !ctrl_a.one_shot && !ctrl_a.reload_sel
        |=> down_count == 8'hff)
        else $error("free restart wrong");
    AST_ONE_SHOT: assert property (dn_uflow && ctrl_a.one_shot && ctrl_a.run && !wr_ctrl_a
        |=> down_done && !dn_tick ##1 down_count == 8'h00)
        else $error("one-shot did not stop");
    AST_PULSE_PIN: assert property (ctrl_a.pulse_en && !cfg_pin2_tone
        |=> shared_port_pin_2_oe && shared_port_pin_2_out == $past(pulse_active ^ ctrl_a.active_low))
        else $error("pulse pin wrong");

    COV_UP_OVF: cover property (up_ovf && up_mode.clk_sel);
    COV_ONE_SHOT: cover property (dn_uflow && ctrl_a.one_shot);
    COV_RELOAD: cover property (dn_uflow && ctrl_a.reload_sel && !ctrl_a.one_shot);
    COV_TONE: cover property (tone_tick && tone_ctrl.en && cfg_pin2_tone);
endmodule : dtp_timers

// *** rtl/dtp_pkg.sv ***
// package: register map, field layouts and reset values of the dual timer block
package dtp_pkg;
    // register byte offsets on the axi4-lite bus
    localparam logic [7:0] ADDR_UP_COUNT = 8'h00;
    localparam logic [7:0] ADDR_UP_MODE = 8'h04;
    localparam logic [7:0] ADDR_POWER_CTRL_1 = 8'h08;
    localparam logic [7:0] ADDR_DOWN_COUNT = 8'h0c;
    localparam logic [7:0] ADDR_DOWN_CTRL_A = 8'h10;
    localparam logic [7:0] ADDR_DOWN_CTRL_B = 8'h14;
    localparam logic [7:0] ADDR_DOWN_PRESC = 8'h18;
    localparam logic [7:0] ADDR_PULSE_DUTY = 8'h1c;
    localparam logic [7:0] ADDR_TONE_CTRL = 8'h20;
    localparam logic [7:0] ADDR_IRQ_FLAG = 8'h24;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h28;
    // bit positions of loose bits
    localparam int BIT_RUN = 0;
    localparam int BIT_GIE = 7;
    localparam int BIT_IRQ_UP = 0;
    localparam int BIT_IRQ_DOWN = 3;
    localparam int BIT_UP_ASSIGN = 3;
    // reset values and fixed restart value
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] DOWN_RESTART = 8'hff;
    localparam logic [7:0] UP_LAST = 8'hff;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef struct packed {
        logic low_clk_sel;
        logic rsv6;
        logic clk_sel;
        logic edge_fall;
        logic assign_other;
        logic [2:0] ratio;
    } dtp_up_mode_type;

    typedef struct packed {
        logic pulse_en;
        logic active_low;
        logic [2:0] rsv;
        logic one_shot;
        logic reload_sel;
        logic run;
    } dtp_ctrl_a_type;

    typedef struct packed {
        logic [1:0] rsv;
        logic clk_sel;
        logic edge_fall;
        logic presc_en_n;
        logic [2:0] ratio;
    } dtp_ctrl_b_type;

    typedef struct packed {
        logic en;
        logic [2:0] rsv;
        logic [3:0] freq;
    } dtp_tone_type;
endpackage : dtp_pkg

// *** rtl/dtp_divider.sv ***
// file: power-of-two tick divider used as prescaler and tone divider
`timescale 1ns/100ps
module dtp_divider #(
    parameter int CNT_W = 8,
    parameter int SEL_W = 3
) (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // control
    input wire logic clear,
    input wire logic tick,
    input wire logic [SEL_W-1:0] sel,
    // results
    output logic out_tick,
    output logic [CNT_W-1:0] value
);
    // the widest ratio must fit the counter
    if ((1 << SEL_W) > CNT_W)
    begin : g_check
        $error("dtp_divider: counter too narrow for select field");
    end

    // code n divides by 2**(n+1)
    function automatic logic [CNT_W-1:0] last_count(input logic [SEL_W-1:0] s);
        last_count = CNT_W'((1 << (s + 1)) - 1);
    endfunction : last_count

    logic [CNT_W-1:0] count;

    // out_tick marks the tick that wraps the counter; a ratio cut below the
    // running count wraps on the next tick instead of running round 256 ticks
    assign out_tick = tick && (count >= last_count(sel));
    assign value = count;

    // count source ticks, clear wins over counting
    always_ff @(posedge aclk)
    begin
        if (!aresetn || clear)
            count <= '0;
        else if (out_tick)
            count <= '0;
        else if (tick)
            count <= count + CNT_W'(1);
    end
endmodule : dtp_divider

// *** dv/dtp_pin_model.sv ***
// partner model: external count pin and slow oscillator
`timescale 1ns/100ps
module dtp_pin_model (
    // clock
    input wire logic aclk,
    // count sources, idle low between bursts
    output logic ext_count_clock_pin,
    output logic slow_internal_osc
);
    logic src = 1'b0;
    assign ext_count_clock_pin = src;
    assign slow_internal_osc = src;
    // four-clock pulses, eight clocks apart, keep the source slower than the instruction clock
    task automatic send(input int n);
        repeat (n)
        begin
            repeat (4) @(posedge aclk);
            src <= 1'b1;
            repeat (4) @(posedge aclk);
            src <= 1'b0;
        end
    endtask : send
endmodule : dtp_pin_model

// *** dv/dual_timer_pwm_buzzer_test.sv ***
// testbench: registers, both timers, pulse and tone output
`timescale 1ns/100ps
module dual_timer_pwm_buzzer_test;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, tone = 0;
    logic async_cfg = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rd;
    logic [1:0] bresp, rresp, rs;
    logic awready, wready, bvalid, arready, rvalid, ext_pin, osc, pin_out, pin_oe, irq_req, last;
    int failures = 0, checks = 0, hi, tg;
    logic [7:0] t_addr [8] = '{8'h00, 8'h04, 8'h0c, 8'h10, 8'h14, 8'h1c, 8'h28, 8'h2c};
    logic [7:0] t_data [8] = '{8'h5a, 8'hbf, 8'h33, 8'hc6, 8'h3f, 8'h55, 8'h09, 8'h77};
    logic [7:0] t_exp [8] = '{8'h5a, 8'hbf, 8'h33, 8'hc6, 8'h3f, 8'h55, 8'h09, 8'h00};
    logic [7:0] e_mode [6] = '{8'h28, 8'h38, 8'ha8, 8'h20, 8'ha1, 8'h28};
    int e_n [6] = '{5, 5, 5, 6, 8, 5};
    logic [7:0] e_exp [6] = '{8'h05, 8'h05, 8'h05, 8'h03, 8'h02, 8'h05};
    logic e_async [6] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};
    dtp_timers i_dtp_timers (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .ext_count_clock_pin(ext_pin),
        .slow_internal_osc(osc), .cfg_async_count(async_cfg), .cfg_pin2_tone(tone),
        .shared_port_pin_2_out(pin_out), .shared_port_pin_2_oe(pin_oe), .irq_req(irq_req));
    dtp_pin_model i_dtp_pin_model (.aclk(aclk), .ext_count_clock_pin(ext_pin), .slow_internal_osc(osc));
    // clock generation
    initial
    begin
        forever #5 aclk = ~aclk;
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // write: address and data offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge aclk);
        awaddr <= a; wdata <= {24'h0, d}; awvalid <= 1; wvalid <= 1; bready <= 1;
        forever
        begin
            @(posedge aclk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            if (bvalid)
            begin
                rs = bresp; bready <= 0; break;
            end
        end
    endtask : wr
    task automatic rdr(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        forever
        begin
            @(posedge aclk);
            if (arready) arvalid <= 0;
            if (rvalid)
            begin
                rd = rdata; rs = rresp; rready <= 0; break;
            end
        end
    endtask : rdr
    // counts high cycles and level changes of the shared pin
    task automatic measure(input int n);
        hi = 0; tg = 0; last = pin_out;
        repeat (n)
        begin
            @(posedge aclk);
            hi += int'(pin_out); tg += int'(pin_out != last); last = pin_out;
        end
    endtask : measure
    task automatic print_verdict;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : print_verdict
    initial
    begin
        #300us failures++;
        print_verdict;
    end
    initial
    begin
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        for (int i = 0; i < 7; i++) begin rdr(t_addr[i]); check("reset", rd, 0); end
        $display("test reset done");
        for (int i = 0; i < 8; i++)
        begin
            wr(t_addr[i], t_data[i]); check("resp", rs, i == 7 ? 2'b10 : 2'b00);
            rdr(t_addr[i]); check("readback", rd, {24'h0, t_exp[i]});
            check("rresp", rs, i == 7 ? 2'b10 : 2'b00);
        end
        $display("test table done");
        wr(8'h04, 8'h08); wr(8'h00, 8'hf0); wr(8'h08, 8'h81); repeat (30) @(posedge aclk);
        wr(8'h08, 8'h80); rdr(8'h24); check("up flag", rd, 1);
        check("irq", irq_req, 1);
        wr(8'h24, 8'h00); rdr(8'h24); check("cleared", rd, 0);
        $display("test overflow done");
        for (int i = 0; i < 6; i++)
        begin
            async_cfg <= e_async[i];
            wr(8'h04, e_mode[i]); wr(8'h00, 8'h00); wr(8'h08, 8'h01);
            i_dtp_pin_model.send(e_n[i]); repeat (6) @(posedge aclk);
            rdr(8'h00); check("edges", rd, e_exp[i]);
            wr(8'h08, 8'h00);
        end
        $display("test sources done");
        wr(8'h14, 8'h08); wr(8'h0c, 8'h03); wr(8'h10, 8'h05); repeat (20) @(posedge aclk);
        rdr(8'h0c); check("one shot", rd, 0);
        rdr(8'h24); check("down flag", rd, 8);
        wr(8'h0c, 8'h05); wr(8'h10, 8'h03); repeat (20) @(posedge aclk);
        rdr(8'h0c); check("reload", rd <= 5, 1);
        wr(8'h0c, 8'h02); wr(8'h10, 8'h01); repeat (20) @(posedge aclk);
        rdr(8'h0c); check("wrap", rd >= 8'he0, 1);
        wr(8'h14, 8'h38); wr(8'h0c, 8'h10); i_dtp_pin_model.send(4); repeat (6) @(posedge aclk);
        rdr(8'h0c); check("down pin", rd, 8'h0c);
        wr(8'h14, 8'h08);
        $display("test down done");
        for (int i = 0; i < 3; i++)
        begin
            wr(8'h1c, i == 2 ? 8'h00 : 8'h02); wr(8'h0c, 8'h05); wr(8'h10, i == 1 ? 8'hc3 : 8'h83);
            repeat (10) @(posedge aclk); measure(60);
            check("pulse oe", pin_oe, 1);
            check("pulse high", hi, i == 0 ? 20 : i == 1 ? 40 : 0);
        end
        $display("test pulse done");
        wr(8'h10, 8'h00); wr(8'h14, 8'h07); wr(8'h10, 8'h01);
        rdr(8'h18); check("presc value", rd, 2);
        wr(8'h14, 8'h00); wr(8'h20, 8'h80); tone <= 1;
        repeat (10) @(posedge aclk); measure(64);
        check("tone oe", pin_oe, 1);
        check("tone edges", tg, 16);
        wr(8'h14, 8'h08); wr(8'h10, 8'h03); wr(8'h0c, 8'h03); wr(8'h20, 8'h88);
        repeat (10) @(posedge aclk); measure(64);
        check("tone timer", tg, 8);
        $display("test tone done");
        print_verdict;
    end
endmodule : dual_timer_pwm_buzzer_test
